// ---- design/sbi_flags.sv ----
// Serial bus acknowledge, command and release flag logic
//
// Notes on behaviour
// - Release flag cleared: start, mismatch, disable, reset
// - Command flag cleared: start, release, disable, reset
// - Ack trigger acks next falling edge, self-clears
// - Ack trigger manual mode; cleared on start, disable
// - Auto enable off: acknowledge only by trigger
// - Auto enable on: acknowledge at 9th falling edge
// - Late auto enable: acknowledge next falling edge
// - Detect flags bits 2,3,6 ignore writes
// - Trigger bits 0,1,4 always read zero
// - Release trigger sets output latch, self-clears
// - Command trigger clears output latch, self-clears
// - Ack detected on rising edge after transfer
// - Interface enable is mode register bit 7
`timescale 1ns/1ps
module sbi_flags #(
    parameter int unsigned ACK_EDGE = sbi_pkg::ACK_FALL_EDGE
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RSTN_I,
    // Avalon-MM slave
    input wire sbi_pkg::bus_req_t AVS_REQ_I,
    output logic AVS_WAITREQUEST_O,
    output logic [sbi_pkg::DATA_W-1:0] AVS_READDATA_O,
    // Transfer events from the shift logic
    input wire sbi_pkg::xfer_evt_t XFER_EVT_I,
    // Serial clock and data pins
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    // Interrupt
    output logic IRQ_O
);
    import sbi_pkg::*;

    if (ACK_EDGE < 1 || ACK_EDGE > 15) begin : g_check
        $error("ACK_EDGE must lie in 1..15");
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    bus_req_t req;
    xfer_evt_t ev;
    logic [1:0] lvl;
    logic [1:0] rise;
    logic [1:0] fall;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic if_enable;
    logic ack_auto_enable;
    logic release_trigger;
    logic command_trigger;
    logic ack_trigger;
    logic release_detected;
    logic command_detected;
    logic ack_detected;
    logic serial_out_latch;
    logic xfer_done;
    logic auto_pending;
    logic ack_window;
    logic [CNT_W-1:0] fall_count;
    ack_state_t ack_state;
    logic [EV_W-1:0] ev_status;
    logic [EV_W-1:0] ev_mask;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] next_status;
    logic [DATA_W-1:0] rd_word;
    logic take;
    logic wr_ctrl;
    logic [DATA_W-1:0] wd;
    logic off;
    logic fire;
    logic ack_detected_set;

    // Address match, shared by the read mux and the write decode
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] o);
        return a == o;
    endfunction : hit

    // Pins are asynchronous to CLK_I
    line_sync #(
        .WIDTH(2),
        .STAGES(SYNC_STAGES)
    ) u_sync (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .line_i({SDA_I, SCL_I}),
        .level_o(lvl),
        .rise_o(rise),
        .fall_o(fall)
    );

    // Pin edges and common terms
    assign req = AVS_REQ_I;
    assign ev = XFER_EVT_I;
    assign scl_rise = rise[0];
    assign scl_fall = fall[0];
    assign sda_lvl = lvl[1];
    assign take = (req.read | req.write) & ~AVS_WAITREQUEST_O;
    assign wd = req.writedata;
    assign wr_ctrl = take & req.write & hit(req.address, OFF_CTRL);
    // Start or disable resets the detect flags, ack trigger and transfer state
    assign off = ~if_enable | ev.xfer_start;

    // Waitrequest drops for one cycle: every access takes two edges
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            AVS_WAITREQUEST_O <= 1'b1;
        end else if (AVS_WAITREQUEST_O && (req.read || req.write)) begin
            AVS_WAITREQUEST_O <= 1'b0;
        end else begin
            AVS_WAITREQUEST_O <= 1'b1;
        end
    end

    // Read mux; unmapped words read zero
    always_comb begin
        rd_word = '0;
        if (hit(req.address, OFF_CTRL)) begin
            rd_word[BIT_RELEASE_DETECTED] = release_detected;
            rd_word[BIT_COMMAND_DETECTED] = command_detected;
            rd_word[BIT_ACK_AUTO_ENABLE] = ack_auto_enable;
            rd_word[BIT_ACK_DETECTED] = ack_detected;
        end else if (hit(req.address, OFF_MODE)) begin
            rd_word[BIT_IF_EN] = if_enable;
        end else if (hit(req.address, OFF_STAT)) begin
            rd_word[EV_W-1:0] = ev_status;
        end else if (hit(req.address, OFF_MASK)) begin
            rd_word[EV_W-1:0] = ev_mask;
        end
    end

    // Data loads with the waitrequest drop so both stand together
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            AVS_READDATA_O <= RDATA_RESET;
        end else if (AVS_WAITREQUEST_O && req.read) begin
            AVS_READDATA_O <= rd_word;
        end
    end

    // Mode register: only the enable bit is held here
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            if_enable <= MODE_RESET[BIT_IF_EN];
        end else if (take && req.write && hit(req.address, OFF_MODE)) begin
            if_enable <= wd[BIT_IF_EN];
        end
    end

    // Auto enable is plain storage, never cleared by hardware
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ack_auto_enable <= CTRL_RESET[BIT_ACK_AUTO_ENABLE];
        end else if (wr_ctrl) begin
            ack_auto_enable <= wd[BIT_ACK_AUTO_ENABLE];
        end
    end

    // Line triggers live one cycle, then drop by themselves
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            release_trigger <= CTRL_RESET[BIT_RELEASE_TRIGGER];
            command_trigger <= CTRL_RESET[BIT_COMMAND_TRIGGER];
        end else begin
            release_trigger <= if_enable & wr_ctrl & wd[BIT_RELEASE_TRIGGER];
            command_trigger <= if_enable & wr_ctrl & wd[BIT_COMMAND_TRIGGER];
        end
    end

    // Output latch; idles high so the open-drain line is released
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            serial_out_latch <= 1'b1;
        end else if (release_trigger) begin
            serial_out_latch <= 1'b1;
        end else if (command_trigger) begin
            serial_out_latch <= 1'b0;
        end
    end

    // Transfer bookkeeping: done flag and falling edge count
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            xfer_done <= 1'b0;
            fall_count <= '0;
        end else if (off) begin
            xfer_done <= 1'b0;
            fall_count <= '0;
        end else begin
            if (ev.xfer_done) begin
                xfer_done <= 1'b1;
            end
            if (scl_fall && fall_count != '1) begin
                fall_count <= fall_count + 1'b1;
            end
        end
    end

    // Acknowledge starts on a falling edge from one of three causes
    assign fire = ~off & scl_fall & (ack_trigger
        | (ack_auto_enable
           && fall_count == CNT_W'(ACK_EDGE - 1))
        | auto_pending);

    // Manual trigger; a write in a falling cycle waits for the next one
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ack_trigger <= CTRL_RESET[BIT_ACK_TRIGGER];
        end else if (off) begin
            ack_trigger <= 1'b0;
        end else if (ack_trigger && scl_fall) begin
            ack_trigger <= 1'b0;
        end else if (wr_ctrl && wd[BIT_ACK_TRIGGER]) begin
            ack_trigger <= 1'b1;
        end
    end

    // Late auto enable: armed by the 0-to-1 write after completion
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            auto_pending <= 1'b0;
        end else if (off || fire || (wr_ctrl && !wd[BIT_ACK_AUTO_ENABLE])) begin
            // Turning auto enable off again cancels a pending late ack
            auto_pending <= 1'b0;
        end else if (wr_ctrl && wd[BIT_ACK_AUTO_ENABLE] && !ack_auto_enable
                     && xfer_done) begin
            auto_pending <= 1'b1;
        end
    end

    // Driver holds the line low for one serial clock period
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ack_state <= ACK_IDLE;
        end else begin
            case (ack_state)
                ACK_IDLE: begin
                    if (fire) begin
                        ack_state <= ACK_DRIVE;
                    end
                end
                ACK_DRIVE: begin
                    // A new cause on the closing edge keeps the line driven
                    if (off || (scl_fall && !fire)) begin
                        ack_state <= ACK_IDLE;
                    end
                end
                default: begin
                    ack_state <= ACK_IDLE;
                end
            endcase
        end
    end

    // Pin drive; low data only, so SDA_O stays zero
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            SDA_O <= 1'b0;
            SDA_OE_O <= 1'b0;
        end else begin
            SDA_O <= 1'b0;
            SDA_OE_O <= if_enable
                & ((ack_state == ACK_DRIVE) | ~serial_out_latch);
        end
    end

    // Acknowledge sampling window: first rising edge after completion
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ack_window <= 1'b0;
        end else if (off || scl_rise) begin
            ack_window <= 1'b0;
        end else if (ev.xfer_done) begin
            ack_window <= 1'b1;
        end
    end

    assign ack_detected_set = ~off & ack_window & scl_rise & ~sda_lvl;

    // Detection flags; software writes never reach them
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ack_detected <= CTRL_RESET[BIT_ACK_DETECTED];
            release_detected <= CTRL_RESET[BIT_RELEASE_DETECTED];
            command_detected <= CTRL_RESET[BIT_COMMAND_DETECTED];
        end else begin
            if (off) begin
                ack_detected <= 1'b0;
            end else if (ack_detected_set) begin
                ack_detected <= 1'b1;
            end
            if (off || ev.addr_mismatch) begin
                release_detected <= 1'b0;
            end else if (ev.rel_seen) begin
                release_detected <= 1'b1;
            end
            if (off || ev.rel_seen) begin
                command_detected <= 1'b0;
            end else if (ev.cmd_seen) begin
                command_detected <= 1'b1;
            end
        end
    end

    // Sticky events: a set in the clearing cycle survives
    always_comb begin
        ev_set = '0;
        ev_set[EV_ACK_DETECTED] = ack_detected_set;
        ev_set[EV_REL] = ~off & ev.rel_seen & ~ev.addr_mismatch;
        ev_set[EV_CMD] = ~off & ev.cmd_seen & ~ev.rel_seen;
        ev_set[EV_ACK_SENT] = fire;
        next_status = ev_status | ev_set;
        if (take && req.write && hit(req.address, OFF_STAT)) begin
            next_status = (ev_status & ~wd[EV_W-1:0]) | ev_set;
        end
    end

    // Status, mask and a registered level interrupt
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ev_status <= EV_RESET;
            ev_mask <= EV_RESET;
            IRQ_O <= 1'b0;
        end else begin
            ev_status <= next_status;
            if (take && req.write && hit(req.address, OFF_MASK)) begin
                ev_mask <= wd[EV_W-1:0];
            end
            IRQ_O <= |(next_status & ev_mask);
        end
    end

    a_trig_read_zero: assert property (
        take && req.read && hit(req.address, OFF_CTRL) |->
        !AVS_READDATA_O[BIT_RELEASE_TRIGGER] && !AVS_READDATA_O[BIT_COMMAND_TRIGGER]
        && !AVS_READDATA_O[BIT_ACK_TRIGGER])
        else $error("trigger bit read back as one");
    a_ro_flag_write: assert property (
        wr_ctrl && !ev.rel_seen && !release_detected |=>
        !release_detected)
        else $error("write reached release flag");
    a_disable_clears: assert property (
        !if_enable |=> !release_detected && !command_detected
        && !ack_detected && !ack_trigger)
        else $error("flag set while interface disabled");
    a_rel_clears_cmd: assert property (
        ev.rel_seen |=> !command_detected)
        else $error("command flag survived release");
    a_mismatch_clears: assert property (
        ev.addr_mismatch || ev.xfer_start |=> !release_detected)
        else $error("release flag survived clear");
    a_manual_ack: assert property (
        ack_trigger && scl_fall && !off |=>
        !ack_trigger && ack_state == ACK_DRIVE ##1 SDA_OE_O)
        else $error("manual acknowledge not driven");
    a_ack_cause: assert property (
        $rose(ack_state == ACK_DRIVE) |->
        $past(ack_trigger) || $past(ack_auto_enable) || $past(auto_pending))
        else $error("acknowledge without a cause");
    a_ninth_edge: assert property (
        ack_auto_enable && scl_fall && !off
        && fall_count == CNT_W'(ACK_EDGE - 1) |=> ack_state == ACK_DRIVE)
        else $error("no acknowledge at ninth falling edge");
    a_late_enable: assert property (
        auto_pending && scl_fall && !off |=>
        ack_state == ACK_DRIVE && ack_auto_enable)
        else $error("late auto acknowledge missing");
    a_latch_follow: assert property (
        release_trigger |=> serial_out_latch && !release_trigger)
        else $error("release trigger did not set latch");
    a_latch_clear: assert property (
        command_trigger && !release_trigger |=> !serial_out_latch)
        else $error("command trigger did not clear latch");
    a_ack_detected_sample: assert property (
        ack_detected_set |=> ack_detected ##1 (IRQ_O || !ev_mask[EV_ACK_DETECTED]))
        else $error("acknowledge not recorded");
    a_trig_cleared: assert property (
        ev.xfer_start |=> !ack_trigger && !auto_pending)
        else $error("ack trigger survived start");
endmodule : sbi_flags

// ---- inc/sbi_pkg.sv ----
// Shared constants and carrier types for the serial bus flag block
package sbi_pkg;
    // Register bus geometry
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 32;
    // Register byte offsets, one aligned word each
    localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_MODE = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_STAT = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_MASK = 5'h0C;
    // Field positions of serial_bus_signal_control
    localparam int unsigned BIT_RELEASE_TRIGGER = 0;
    localparam int unsigned BIT_COMMAND_TRIGGER = 1;
    localparam int unsigned BIT_RELEASE_DETECTED = 2;
    localparam int unsigned BIT_COMMAND_DETECTED = 3;
    localparam int unsigned BIT_ACK_TRIGGER = 4;
    localparam int unsigned BIT_ACK_AUTO_ENABLE = 5;
    localparam int unsigned BIT_ACK_DETECTED = 6;
    // Field position of the enable inside serial_mode_reg
    localparam int unsigned BIT_IF_EN = 7;
    // Event status and mask layout
    localparam int unsigned EV_W = 4;
    localparam int unsigned EV_ACK_DETECTED = 0;
    localparam int unsigned EV_REL = 1;
    localparam int unsigned EV_CMD = 2;
    localparam int unsigned EV_ACK_SENT = 3;
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [EV_W-1:0] EV_RESET = 4'h0;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
    // Timing counts on the serial and system clocks
    localparam int unsigned ACK_FALL_EDGE = 9;
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned CNT_W = 4;

    // Avalon-MM request as the master drives it
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
    } bus_req_t;

    // Pulses from the shift and address logic, same clock
    typedef struct packed {
        logic xfer_start;
        logic xfer_done;
        logic addr_mismatch;
        logic rel_seen;
        logic cmd_seen;
    } xfer_evt_t;

    // Acknowledge driver states
    typedef enum logic [0:0] {
        ACK_IDLE = 1'b0,
        ACK_DRIVE = 1'b1
    } ack_state_t;
endpackage : sbi_pkg

// ---- design/line_sync.sv ----
// Pin synchroniser with edge detection behind the last stage
`timescale 1ns/1ps
module line_sync #(
    parameter int unsigned WIDTH = 2,
    parameter int unsigned STAGES = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Raw pins
    input wire logic [WIDTH-1:0] line_i,
    // Synchronised level and one-cycle edges
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] fall_o
);
    logic [WIDTH-1:0] stage [STAGES];
    logic [WIDTH-1:0] last;

    if (STAGES < 2) begin : g_check
        $error("line_sync needs at least two stages");
    end

    // Chain; only the next stage reads the first one
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < STAGES; i++) begin
                stage[i] <= '1;
            end
            last <= '1;
        end else begin
            stage[0] <= line_i;
            for (int i = 1; i < STAGES; i++) begin
                stage[i] <= stage[i-1];
            end
            last <= stage[STAGES-1];
        end
    end

    // Edges compare the settled stage with its delayed copy
    assign level_o = stage[STAGES-1];
    assign rise_o = stage[STAGES-1] & ~last;
    assign fall_o = ~stage[STAGES-1] & last;
endmodule : line_sync

// ---- tb/sbus_peer.sv ----
// Far-side serial bus device: clocks frames, may acknowledge
`timescale 1ns/1ps
module sbus_peer (
    // Link pins as seen by the far side
    output logic scl_o,
    output logic sda_o
);
    // Clock idles high between frames, data released to pull-up
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // Clock n bits at 160 ns; ack pulls data low on the last bit
    task frame(input int n, input logic ack);
        for (int i = 0; i < n; i++) begin
            #7;
            scl_o = 1'b0;
            if (ack && i == n - 1) begin
                sda_o = 1'b0; // Acknowledge from the far side
            end
            #80;
            scl_o = 1'b1;
            #73;
            sda_o = 1'b1; // Released line returns to pull-up level
        end
    endtask : frame
endmodule : sbus_peer

// ---- tb/serial_bus_ack_cmd_flags_test.sv ----
// Self-checking bench for the serial bus flag block
`timescale 1ns/1ps
module serial_bus_ack_cmd_flags_test;
    import sbi_pkg::*;
    logic CLK_I = 1'b0;
    logic RSTN_I = 1'b0;
    bus_req_t req = '0;
    xfer_evt_t evt = '0;
    logic wait_o;
    logic [DATA_W-1:0] rdata;
    logic scl, peer_sda, sda_line, sda_o, sda_oe, irq;
    logic [DATA_W-1:0] q;
    int failures = 0;
    int n_tests = 0;
    int nfall = 0;
    int oe_fall = -1;

    // Open-drain data line: device pulls low, else peer level
    assign sda_line = sda_oe ? 1'b0 : peer_sda;

    // 50 MHz system clock
    initial begin
        forever #10 CLK_I = ~CLK_I;
    end

    sbus_peer peer (.scl_o(scl), .sda_o(peer_sda));

    sbi_flags #(.ACK_EDGE(ACK_FALL_EDGE)) uut (
        .CLK_I(CLK_I), .RSTN_I(RSTN_I), .AVS_REQ_I(req),
        .AVS_WAITREQUEST_O(wait_o), .AVS_READDATA_O(rdata),
        .XFER_EVT_I(evt), .SCL_I(scl), .SDA_I(sda_line),
        .SDA_O(sda_o), .SDA_OE_O(sda_oe), .IRQ_O(irq)
    );

    // Count pin falls and note the fall at which acknowledge began
    always @(negedge scl) nfall++;
    always @(posedge sda_oe) oe_fall = nfall;

    task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task finish_test;
        $display("checks=%0d mismatches=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // One Avalon access; held until waitrequest is sampled low
    task bus(input logic w, input logic [ADDR_W-1:0] a,
             input logic [DATA_W-1:0] d);
        int i;
        @(posedge CLK_I);
        req <= '{read: ~w, write: w, address: a, writedata: d};
        i = 0;
        do begin
            @(posedge CLK_I);
            i++;
        end while (wait_o !== 1'b0 && i < 20);
        if (wait_o !== 1'b0) begin
            failures++;
            finish_test();
        end
        q = rdata;
        req <= '0;
    endtask : bus

    task rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        bus(1'b0, a, '0);
        check(q, exp);
    endtask : rd_chk

    // One-cycle event pulse from the shift logic
    task pulse(input xfer_evt_t e);
        @(posedge CLK_I);
        evt <= e;
        @(posedge CLK_I);
        evt <= '0;
    endtask : pulse

    task clks(input int n);
        repeat (n) @(posedge CLK_I);
    endtask : clks

    task start_frame;
        pulse('{xfer_start: 1'b1, default: 1'b0});
        nfall = 0;
        oe_fall = -1;
    endtask : start_frame

    task s_reset;
        rd_chk(OFF_CTRL, 32'h0000_0000);
        rd_chk(OFF_MODE, 32'h0000_0000);
        rd_chk(OFF_STAT, 32'h0000_0000);
        rd_chk(OFF_MASK, 32'h0000_0000);
        rd_chk(5'h10, 32'h0000_0000);
        check(sda_oe, 1'b0);
        check({irq, sda_o}, 2'b00);
    endtask : s_reset

    // Interface off: triggers and detect flags stay zero
    task s_disabled;
        bus(1'b1, OFF_CTRL, 32'h0000_0013);
        pulse('{cmd_seen: 1'b1, default: 1'b0});
        rd_chk(OFF_CTRL, 32'h0000_0000);
        check(sda_oe, 1'b0);
    endtask : s_disabled

    // Command trigger drops the output latch, release trigger raises it
    task s_latch;
        bus(1'b1, OFF_MODE, 32'h0000_0080);
        rd_chk(OFF_MODE, 32'h0000_0080);
        bus(1'b1, OFF_CTRL, 32'h0000_0002);
        clks(4);
        check(sda_oe, 1'b1);
        rd_chk(OFF_CTRL, 32'h0000_0000);
        bus(1'b1, OFF_CTRL, 32'h0000_0001);
        clks(4);
        check(sda_oe, 1'b0);
        rd_chk(OFF_CTRL, 32'h0000_0000);
    endtask : s_latch

    // Detect flags: set, clear conditions, write immunity, interrupt
    task s_flags;
        pulse('{cmd_seen: 1'b1, default: 1'b0});
        bus(1'b1, OFF_CTRL, 32'h0000_0044);
        rd_chk(OFF_CTRL, 32'h0000_0008);
        pulse('{rel_seen: 1'b1, default: 1'b0});
        rd_chk(OFF_CTRL, 32'h0000_0004);
        pulse('{addr_mismatch: 1'b1, default: 1'b0});
        rd_chk(OFF_CTRL, 32'h0000_0000);
        pulse('{rel_seen: 1'b1, default: 1'b0});
        pulse('{cmd_seen: 1'b1, default: 1'b0});
        rd_chk(OFF_CTRL, 32'h0000_000C);
        pulse('{xfer_start: 1'b1, default: 1'b0});
        rd_chk(OFF_CTRL, 32'h0000_0000);
        rd_chk(OFF_STAT, 32'h0000_0006);
        check(irq, 1'b0);
        bus(1'b1, OFF_MASK, 32'h0000_0002);
        clks(3);
        check(irq, 1'b1);
        bus(1'b1, OFF_STAT, 32'h0000_0002);
        clks(3);
        check(irq, 1'b0);
        rd_chk(OFF_STAT, 32'h0000_0004);
        pulse('{cmd_seen: 1'b1, default: 1'b0});
        bus(1'b1, OFF_MODE, 32'h0000_0000);
        rd_chk(OFF_CTRL, 32'h0000_0000);
        bus(1'b1, OFF_MODE, 32'h0000_0080);
        bus(1'b1, OFF_STAT, 32'h0000_000F);
    endtask : s_flags

    // Manual acknowledge only through the trigger bit
    task s_manual;
        bus(1'b1, OFF_CTRL, 32'h0000_0010);
        start_frame();
        peer.frame(9, 1'b0);
        clks(6);
        check(oe_fall, -1);
        start_frame();
        peer.frame(8, 1'b0);
        pulse('{xfer_done: 1'b1, default: 1'b0});
        peer.frame(1, 1'b1);
        rd_chk(OFF_CTRL, 32'h0000_0040);
        check(oe_fall, -1);
        // Trigger only with auto enable off, as software must
        bus(1'b1, OFF_CTRL, 32'h0000_0010);
        rd_chk(OFF_CTRL, 32'h0000_0040);
        nfall = 0;
        peer.frame(1, 1'b0);
        check(oe_fall, 1);
        peer.frame(1, 1'b0);
        clks(6);
        check(sda_oe, 1'b0);
        rd_chk(OFF_STAT, 32'h0000_0009);
    endtask : s_manual

    // Automatic acknowledge at the counted falling edge
    task s_auto;
        bus(1'b1, OFF_CTRL, 32'h0000_0020);
        start_frame();
        peer.frame(ACK_FALL_EDGE, 1'b0);
        clks(6);
        check(oe_fall, ACK_FALL_EDGE);
        peer.frame(1, 1'b0);
        bus(1'b0, OFF_CTRL, '0);
        check(q & 32'h0000_0020, 32'h0000_0020);
    endtask : s_auto

    // Auto enable written after completion acks on the next fall
    task s_late;
        bus(1'b1, OFF_CTRL, 32'h0000_0000);
        start_frame();
        peer.frame(8, 1'b0);
        pulse('{xfer_done: 1'b1, default: 1'b0});
        // Ninth fall passes unacknowledged, so only the late path can ack
        peer.frame(1, 1'b0);
        clks(6);
        check(oe_fall, -1);
        bus(1'b1, OFF_CTRL, 32'h0000_0020);
        peer.frame(1, 1'b0);
        clks(6);
        check(oe_fall, 10);
        peer.frame(1, 1'b0);
        bus(1'b0, OFF_CTRL, '0);
        check(q & 32'h0000_0020, 32'h0000_0020);
    endtask : s_late

    // Main sequence
    initial begin
        clks(2);
        RSTN_I <= 1'b1;
        s_reset();
        s_disabled();
        s_latch();
        s_flags();
        s_manual();
        s_auto();
        s_late();
        finish_test();
    end
endmodule : serial_bus_ack_cmd_flags_test
